// ### design/fast_pcs_cfg.svh
// constants of the 100 Mb/s coding-sublayer configuration register
`ifndef FAST_PCS_CFG_SVH
`define FAST_PCS_CFG_SVH

// ****************************************
// register placement
// ****************************************
`define PCS_CFG_INDEX       12'h016
`define PCS_CFG_BYTE_ADDR   12'h058
`define PCS_CFG_ADDR_W      12

// ****************************************
// field positions
// ****************************************
`define PCS_TQ_BIT          10
`define PCS_SD_FORCE_BIT    9
`define PCS_SD_ALG_BIT      8
`define PCS_DESCRAMBLER_TIMEOUT_SELECT_BIT   7
`define PCS_FORCE_100_BIT   5
`define PCS_NRZI_BYP_BIT    2

// ****************************************
// masks and reset value
// ****************************************
`define PCS_CFG_RW_MASK     16'h07a4
`define PCS_CFG_MBZ_MASK    16'h185b
`define PCS_CFG_RESET       16'h0100

// ****************************************
// timing
// ****************************************
`define PCLK_PERIOD_NS      5
`define DESC_TMO_LONG_NS    2000000
`define DESC_TMO_SHORT_NS   722000
`define DESC_TMO_W          19

`endif

// ### design/fast_pcs_pkg.sv
// types of the 100 Mb/s coding-sublayer configuration register
package fast_pcs_pkg;

  // ****************************************
  // control bits handed to the coding sublayer
  // ****************************************
  typedef struct packed {
    logic transmit_true_quiet_enable;
    logic force_signal_detect;
    logic signal_detect_algorithm_select;
    logic descrambler_timeout_select;
    logic force_100_good_link;
    logic nrzi_bypass;
  } pcs_ctrl_t;

  // ****************************************
  // apb slave phase
  // ****************************************
  typedef enum logic [0:0] {
    PH_IDLE = 1'b0,
    PH_ANSWER = 1'b1
  } apb_phase_t;

endpackage

// ### design/fast_pcs_config_register.sv
// apb slave holding the 100 Mb/s coding-sublayer configuration register
// Function
// - The register sits at index 0x16 of the register space, byte address 0x58, 16 bits wide.
// - Bits 15 to 13 always read as zero and writes to them are discarded.
// - Bit 10 is read-write, resets to 0, and selects true quiet transmit mode when 1.
// - Bit 9 is read-write, resets to 0, and forces signal detection in the PMA when 1.
// - Bit 8 is read-write, resets to 1, and picks the enhanced signal-detect algorithm when 1.
// - Bit 7 is read-write, resets to 0, and sets the descrambler timeout to 2ms or 722us.
// - Bit 5 is read-write, resets to 0, and forces a good 100 Mb/s link report when 1.
// - Bit 2 is read-write, resets to 0, and bypasses the NRZI coding stage when 1.
//
// Our own choice: the APB slave port.
`timescale 1ns/10ps
`include "fast_pcs_cfg.svh"

module fast_pcs_config_register #(
  parameter int unsigned TMO_LONG_CYC  = `DESC_TMO_LONG_NS / `PCLK_PERIOD_NS,
  parameter int unsigned TMO_SHORT_CYC = `DESC_TMO_SHORT_NS / `PCLK_PERIOD_NS
) (
  // clock, reset, enable
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  input  wire logic                          pce,
  // apb slave
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [`PCS_CFG_ADDR_W-1:0]    paddr,
  input  wire logic [31:0]                   pwdata,
  input  wire logic [3:0]                    pstrb,
  output logic      [31:0]                   prdata,
  output logic                               pready,
  output logic                               pslverr,
  // controls to the coding sublayer
  output fast_pcs_pkg::pcs_ctrl_t            pcs_ctrl,
  output logic      [`DESC_TMO_W-1:0]        descrambler_timeout_cycles
);

  // ****************************************
  // declarations
  // ****************************************
  localparam logic [`DESC_TMO_W-1:0] TMO_LONG  = TMO_LONG_CYC[`DESC_TMO_W-1:0];
  localparam logic [`DESC_TMO_W-1:0] TMO_SHORT = TMO_SHORT_CYC[`DESC_TMO_W-1:0];

  fast_pcs_pkg::apb_phase_t   phase_r;
  fast_pcs_pkg::apb_phase_t   phase_nxt;
  logic [15:0]                cfg_r;
  logic [15:0]                cfg_nxt;
  logic [31:0]                prdata_r;
  logic [31:0]                prdata_nxt;
  logic                       pslverr_r;
  logic                       pslverr_nxt;
  logic [`DESC_TMO_W-1:0]     tmo_r;
  logic [`DESC_TMO_W-1:0]     tmo_nxt;

  wire                        access;
  wire                        addr_hit;
  wire                        first_access;
  wire                        wr_go;
  wire  [15:0]                lane_mask;
  wire  [15:0]                wr_mask;
  wire  [15:0]                cfg_read;

  // ****************************************
  // decode
  // ****************************************
  assign access       = pce & psel & penable;
  assign addr_hit     = (paddr == `PCS_CFG_BYTE_ADDR);
  assign first_access = access & (phase_r == fast_pcs_pkg::PH_IDLE);
  // write lands only at the edge where the master sees pready high
  assign wr_go        = access & (phase_r == fast_pcs_pkg::PH_ANSWER) & pwrite & ~pslverr_r;
  assign lane_mask    = {{8{pstrb[1]}}, {8{pstrb[0]}}};
  // reserved bits never stored, so they cannot leak onto the sublayer
  assign wr_mask      = lane_mask & `PCS_CFG_RW_MASK;
  assign cfg_read     = cfg_r & `PCS_CFG_RW_MASK;

  // ****************************************
  // next values
  // ****************************************
  // one wait state buys registered prdata, pready and pslverr
  always_comb begin
    case (phase_r)
      fast_pcs_pkg::PH_IDLE: begin
        phase_nxt = first_access ? fast_pcs_pkg::PH_ANSWER : fast_pcs_pkg::PH_IDLE;
      end
      fast_pcs_pkg::PH_ANSWER: begin
        phase_nxt = access ? fast_pcs_pkg::PH_IDLE : fast_pcs_pkg::PH_ANSWER;
      end
      default: begin
        phase_nxt = fast_pcs_pkg::PH_IDLE;
      end
    endcase
  end

  assign pslverr_nxt = first_access ? ~addr_hit : (access ? 1'b0 : pslverr_r);
  assign prdata_nxt  = (first_access & ~pwrite & addr_hit) ? {16'h0000, cfg_read} :
                       (first_access ? 32'h0000_0000 : prdata_r);
  assign cfg_nxt     = wr_go ? ((cfg_r & ~wr_mask) | (pwdata[15:0] & wr_mask)) : cfg_r;
  assign tmo_nxt     = cfg_r[`PCS_DESCRAMBLER_TIMEOUT_SELECT_BIT] ? TMO_LONG : TMO_SHORT;

  // ****************************************
  // state
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_r   <= fast_pcs_pkg::PH_IDLE;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    end else if (pce) begin
      phase_r   <= phase_nxt;
      pslverr_r <= pslverr_nxt;
      prdata_r  <= prdata_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_r <= `PCS_CFG_RESET;
    end else if (pce) begin
      cfg_r <= cfg_nxt;
    end
  end

  // count registered so the sublayer sees it straight from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tmo_r <= TMO_SHORT;
    end else if (pce) begin
      tmo_r <= tmo_nxt;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign prdata  = prdata_r;
  // limitation: pce low in the answer cycle holds pready, keep pce high there
  assign pready  = (phase_r == fast_pcs_pkg::PH_ANSWER);
  assign pslverr = pslverr_r;
  assign descrambler_timeout_cycles = tmo_r;

  assign pcs_ctrl.transmit_true_quiet_enable     = cfg_r[`PCS_TQ_BIT];
  assign pcs_ctrl.force_signal_detect            = cfg_r[`PCS_SD_FORCE_BIT];
  assign pcs_ctrl.signal_detect_algorithm_select = cfg_r[`PCS_SD_ALG_BIT];
  assign pcs_ctrl.descrambler_timeout_select     = cfg_r[`PCS_DESCRAMBLER_TIMEOUT_SELECT_BIT];
  assign pcs_ctrl.force_100_good_link            = cfg_r[`PCS_FORCE_100_BIT];
  assign pcs_ctrl.nrzi_bypass                    = cfg_r[`PCS_NRZI_BYP_BIT];

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  property p_addr_hit;
    first_access & addr_hit |=> pready & ~pslverr;
  endproperty
  a_addr_hit: assert property (p_addr_hit)
    else $error("mapped access not answered cleanly");

  property p_addr_miss;
    first_access & ~addr_hit & ~pwrite |=> pready & pslverr & (prdata == 32'h0000_0000);
  endproperty
  a_addr_miss: assert property (p_addr_miss)
    else $error("unmapped access not flagged");

  property p_reserved_zero;
    (prdata & ~{16'h0000, `PCS_CFG_RW_MASK}) == 32'h0000_0000;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved bits read non-zero");

  property p_reserved_store;
    (cfg_r & ~`PCS_CFG_RW_MASK) == 16'h0000;
  endproperty
  a_reserved_store: assert property (p_reserved_store)
    else $error("reserved bits hold a value");

  property p_tq_write;
    wr_go & pstrb[1] |=> pcs_ctrl.transmit_true_quiet_enable == $past(pwdata[`PCS_TQ_BIT]);
  endproperty
  a_tq_write: assert property (p_tq_write)
    else $error("true quiet bit not written");

  property p_sd_force_hold;
    wr_go & ~pstrb[1] |=> $stable(pcs_ctrl.force_signal_detect)
      & $stable(pcs_ctrl.signal_detect_algorithm_select);
  endproperty
  a_sd_force_hold: assert property (p_sd_force_hold)
    else $error("upper lane changed without its strobe");

  property p_sd_alg_reset;
    $rose(presetn) |-> pcs_ctrl.signal_detect_algorithm_select & ~pcs_ctrl.force_signal_detect;
  endproperty
  a_sd_alg_reset: assert property (p_sd_alg_reset)
    else $error("signal detect reset values wrong");

  property p_timeout;
    pce |=> descrambler_timeout_cycles ==
      ($past(pcs_ctrl.descrambler_timeout_select) ? TMO_LONG : TMO_SHORT);
  endproperty
  a_timeout: assert property (p_timeout)
    else $error("timeout count does not follow select");

  property p_force_100_write;
    wr_go & pstrb[0] |=> pcs_ctrl.force_100_good_link == $past(pwdata[`PCS_FORCE_100_BIT])
      & pcs_ctrl.descrambler_timeout_select == $past(pwdata[`PCS_DESCRAMBLER_TIMEOUT_SELECT_BIT]);
  endproperty
  a_force_100_write: assert property (p_force_100_write)
    else $error("low lane bits not written");

  property p_nrzi_read;
    first_access & addr_hit & ~pwrite |=> prdata[`PCS_NRZI_BYP_BIT] == $past(cfg_r[2]);
  endproperty
  a_nrzi_read: assert property (p_nrzi_read)
    else $error("bypass bit read back wrong");

  property p_no_write_hold;
    ~wr_go |=> $stable(cfg_r);
  endproperty
  a_no_write_hold: assert property (p_no_write_hold)
    else $error("register changed without a write");

  property p_ready_pulse;
    pready & pce |=> ~pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse)
    else $error("pready held past its cycle");

  property p_refused_write;
    pready & pslverr |=> $stable(cfg_r);
  endproperty
  a_refused_write: assert property (p_refused_write)
    else $error("refused access changed the register");

  property p_err_with_ready;
    pslverr |-> pready;
  endproperty
  a_err_with_ready: assert property (p_err_with_ready)
    else $error("pslverr outside the answer cycle");

  property p_answer_after_access;
    $rose(pready) |-> $past(first_access);
  endproperty
  a_answer_after_access: assert property (p_answer_after_access)
    else $error("pready without a taken access");

  property p_read_word;
    first_access & addr_hit & ~pwrite |=>
      prdata == {16'h0000, $past(cfg_r) & `PCS_CFG_RW_MASK};
  endproperty
  a_read_word: assert property (p_read_word)
    else $error("read word does not match the register");

  property p_tq_hold;
    wr_go & ~pstrb[1] |=> $stable(pcs_ctrl.transmit_true_quiet_enable);
  endproperty
  a_tq_hold: assert property (p_tq_hold)
    else $error("true quiet bit changed without its strobe");

  property p_sd_force_write;
    wr_go & pstrb[1] |=> pcs_ctrl.force_signal_detect == $past(pwdata[`PCS_SD_FORCE_BIT]);
  endproperty
  a_sd_force_write: assert property (p_sd_force_write)
    else $error("signal detect force bit not written");

  property p_sd_alg_write;
    wr_go & pstrb[1] |=> pcs_ctrl.signal_detect_algorithm_select == $past(pwdata[`PCS_SD_ALG_BIT]);
  endproperty
  a_sd_alg_write: assert property (p_sd_alg_write)
    else $error("signal detect algorithm bit not written");

  property p_low_lane_hold;
    wr_go & ~pstrb[0] |=> $stable(pcs_ctrl.descrambler_timeout_select)
      & $stable(pcs_ctrl.force_100_good_link) & $stable(pcs_ctrl.nrzi_bypass);
  endproperty
  a_low_lane_hold: assert property (p_low_lane_hold)
    else $error("low lane changed without its strobe");

  property p_tmo_values;
    (descrambler_timeout_cycles == TMO_LONG) | (descrambler_timeout_cycles == TMO_SHORT);
  endproperty
  a_tmo_values: assert property (p_tmo_values)
    else $error("timeout count is neither length");

  property p_nrzi_write;
    wr_go & pstrb[0] |=> pcs_ctrl.nrzi_bypass == $past(pwdata[`PCS_NRZI_BYP_BIT]);
  endproperty
  a_nrzi_write: assert property (p_nrzi_write)
    else $error("bypass bit not written");

  property p_reset_low_bits;
    $rose(presetn) |-> ~pcs_ctrl.transmit_true_quiet_enable & ~pcs_ctrl.nrzi_bypass
      & ~pcs_ctrl.descrambler_timeout_select & ~pcs_ctrl.force_100_good_link
      & (descrambler_timeout_cycles == TMO_SHORT);
  endproperty
  a_reset_low_bits: assert property (p_reset_low_bits)
    else $error("control reset values wrong");

  property p_pce_freeze;
    ~pce |=> $stable(cfg_r) & $stable(prdata) & $stable(pready) & $stable(pslverr);
  endproperty
  a_pce_freeze: assert property (p_pce_freeze)
    else $error("state moved while the enable was low");

  c_write: cover property (wr_go & pstrb[1] & pstrb[0]);
  c_read: cover property (first_access & addr_hit & ~pwrite ##1 pready);
  c_miss: cover property (first_access & ~addr_hit ##1 pslverr);
  c_long_tmo: cover property (descrambler_timeout_cycles == TMO_LONG);
  c_refused_write: cover property (first_access & ~addr_hit & pwrite ##1 pslverr);

endmodule

// ### sim/fast_pcs_config_register_test.sv
// self-checking bench for the coding-sublayer configuration register
`timescale 1ns/10ps
`include "fast_pcs_cfg.svh"

module fast_pcs_config_register_test;
  localparam int unsigned LONG_C  = 40;
  localparam int unsigned SHORT_C = 14;

  // ****************************************
  // signals
  // ****************************************
  logic                         pclk;
  logic                         presetn;
  logic                         pce;
  logic                         psel;
  logic                         penable;
  logic                         pwrite;
  logic [`PCS_CFG_ADDR_W-1:0]   paddr;
  logic [31:0]                  pwdata;
  logic [3:0]                   pstrb;
  logic [31:0]                  prdata;
  logic                         pready;
  logic                         pslverr;
  fast_pcs_pkg::pcs_ctrl_t      pcs_ctrl;
  logic [`DESC_TMO_W-1:0]       descrambler_timeout_cycles;
  int                           fail_count;
  int                           n_compared;
  integer                       seed;
  logic [15:0]                  exp_r;

  fast_pcs_config_register #(.TMO_LONG_CYC(LONG_C), .TMO_SHORT_CYC(SHORT_C)) uut (
    .pclk(pclk), .presetn(presetn), .pce(pce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pcs_ctrl(pcs_ctrl),
    .descrambler_timeout_cycles(descrambler_timeout_cycles));

  // ****************************************
  // clock and watchdog
  // ****************************************
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  initial begin
    repeat (20000) @(posedge pclk);
    fail_count++;
    stop_test();
  end

  // ****************************************
  // helpers
  // ****************************************
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic stop_test();
    if (fail_count == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // one apb transfer, entered just after a rising edge; model and compare at completion
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      input logic [3:0] s);
    logic [15:0] lane;
    logic        hit;
    int          n;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d & ~{16'h0000, `PCS_CFG_MBZ_MASK};
    pstrb   <= s;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    hit = (a == `PCS_CFG_BYTE_ADDR);
    check("pready", {31'h0, pready}, 32'h1);
    check("pslverr", {31'h0, pslverr}, {31'h0, ~hit});
    if (!wr)
      check("prdata", prdata, hit ? {16'h0, exp_r} : 32'h0);
    psel    <= 1'b0;
    penable <= 1'b0;
    lane = {{8{s[1]}}, {8{s[0]}}};
    if (wr && hit)
      exp_r = (exp_r & ~lane) | (d[15:0] & lane & `PCS_CFG_RW_MASK);
    // idle for one edge so a following call never reassigns psel in this step
    @(posedge pclk);
  endtask

  // controls follow the register at once and the timeout count one edge later
  task automatic outs();
    repeat (2) @(posedge pclk);
    check("pcs_ctrl", {26'h0, pcs_ctrl},
          {26'h0, exp_r[10], exp_r[9], exp_r[8], exp_r[7], exp_r[5], exp_r[2]});
    check("timeout", {13'h0, descrambler_timeout_cycles},
          exp_r[7] ? LONG_C : SHORT_C);
  endtask

  task automatic do_reset();
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    exp_r = `PCS_CFG_RESET;
    @(posedge pclk);
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    fail_count = 0;
    n_compared = 0;
    seed = 44;
    presetn = 1'b0;
    pce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'h0;
    do_reset();
    outs();
    xfer(1'b0, `PCS_CFG_BYTE_ADDR, 32'h0, 4'h0);
    // walking one across every bit but the must-be-zero ones, read back at once
    for (int i = 0; i < 32; i++) begin
      xfer(1'b1, `PCS_CFG_BYTE_ADDR, 32'h1 << i, 4'hf);
      xfer(1'b0, `PCS_CFG_BYTE_ADDR, 32'h0, 4'h0);
      outs();
    end
    // random data, strobes and addresses, unmapped ones refused
    for (int i = 0; i < 60; i++) begin
      logic [11:0] a;
      a = ($random(seed) & 1) ? `PCS_CFG_BYTE_ADDR : 12'(($random(seed) & 32'hffc));
      xfer(1'b1, a, $random(seed), 4'($random(seed)));
      xfer(1'b0, ($random(seed) & 1) ? `PCS_CFG_BYTE_ADDR : a, 32'h0, 4'h0);
      outs();
    end
    // enable low holds the access off; it completes once the enable returns
    pce <= 1'b0;
    fork
      xfer(1'b1, `PCS_CFG_BYTE_ADDR, 32'h0000_0484, 4'hf);
      begin
        repeat (3) begin
          @(posedge pclk);
          check("pready", {31'h0, pready}, 32'h0);
        end
        pce <= 1'b1;
      end
    join
    outs();
    // reset in mid-run restores the defaults
    xfer(1'b1, `PCS_CFG_BYTE_ADDR, 32'hffff_ffff, 4'hf);
    outs();
    do_reset();
    outs();
    xfer(1'b0, `PCS_CFG_BYTE_ADDR, 32'h0, 4'h0);
    stop_test();
  end
endmodule
